// [hdl/tcer_pkg.sv]
// Package of constants and types for the timer clock, event and reload slice
package tcer_pkg;
   localparam logic [3:0] TCER_OFS_MODE_CTRL = 4'h0;
   localparam logic [3:0] TCER_OFS_CLK_EVT = 4'h4;
   localparam logic [3:0] TCER_OFS_RELOAD = 4'h8;
   localparam logic [3:0] TCER_OFS_COUNT = 4'hC;
   localparam int TCER_ADDR_W = 4;
   localparam int TCER_CNT_W = 16;
   localparam int TCER_SEL_W = 4;
   localparam int TCER_DIV_W = 8;
   localparam int TCER_FILTER_CLOCK_SELECT_LSB = 8;
   localparam int TCER_FILTER_CLOCK_SELECT_MSB = 11;
   localparam int TCER_COUNT_CLOCK_SELECT_LSB = 0;
   localparam int TCER_COUNT_CLOCK_SELECT_MSB = 3;
   localparam int TCER_EVSRC_BIT = 7;
   localparam int TCER_EDGE_LSB = 5;
   localparam int TCER_EDGE_MSB = 6;
   localparam int TCER_EN_BIT = 0;
   localparam int TCER_MODE_LSB = 2;
   localparam int TCER_MODE_MSB = 3;
   localparam int TCER_DIR_BIT = 4;
   localparam int TCER_RELOAD_MSB = 15;
   localparam logic [11:0] TCER_CLK_EVT_RST = 12'h000;
   localparam logic [15:0] TCER_RELOAD_RST = 16'hFFFF;
   localparam logic [15:0] TCER_CNT_MAX = 16'hFFFF;
   localparam logic [15:0] TCER_CNT_MIN = 16'h0000;
   localparam logic [15:0] TCER_CNT_ONE = 16'h0001;
   localparam logic [3:0] TCER_SEL_MAX = 4'h7;
   localparam int TCER_FILT_LEN = 3;
   typedef enum logic [1:0] {
      TCER_MODE_TIMER = 2'b00,
      TCER_MODE_EVENT = 2'b01,
      TCER_MODE_ONESHOT = 2'b10,
      TCER_MODE_MEASURE = 2'b11
   } tcer_mode_type;
   typedef enum logic [1:0] {
      TCER_EDGE_FALL = 2'b00,
      TCER_EDGE_RISE = 2'b01,
      TCER_EDGE_BOTH = 2'b10,
      TCER_EDGE_NONE = 2'b11
   } tcer_edge_type;
endpackage

// [hdl/tcer_tick_if.sv]
// Tick carrier between the divider, the filter and the timer core
`timescale 1ns/1ps
`default_nettype none
interface tcer_tick_if;
   logic [3:0] count_clock_select;
   logic [3:0] filter_clock_select;
   logic count_tick;
   logic filter_tick;
   logic raw_in;
   logic filt_in;
   modport core (output count_clock_select, output filter_clock_select, output raw_in,
      input count_tick, input filter_tick, input filt_in);
   modport gen (input count_clock_select, input filter_clock_select, input raw_in,
      output count_tick, output filter_tick, output filt_in);
endinterface
`default_nettype wire

// [hdl/tcer_tickgen.sv]
// Prescaler ticks and input noise filter
`timescale 1ns/1ps
`default_nettype none
module tcer_tickgen (
   input wire logic clk,
   input wire logic rst,
   tcer_tick_if.gen tk
);
   typedef struct packed {
      logic [tcer_pkg::TCER_DIV_W-1:0] div;
      logic [tcer_pkg::TCER_FILT_LEN-1:0] hist;
      logic filt;
   } tcer_tg_type;
   tcer_tg_type s_reg, s_next;

   // Code n ticks once every 2**n cycles; reserved codes never tick
   function automatic logic tick_of(input logic [3:0] sel, input logic [7:0] d);
      logic [7:0] m;
      m = 8'h00;
      if (sel > tcer_pkg::TCER_SEL_MAX) begin
         tick_of = 1'b0;
      end else begin
         m = 8'(({8'h00, 8'h01} << sel) - 16'h0001);
         tick_of = ((d & m) == m);
      end
   endfunction

   always_comb begin
      s_next = s_reg;
      s_next.div = s_reg.div + 8'h01;
      if (tk.filter_tick) begin
         s_next.hist = {s_reg.hist[tcer_pkg::TCER_FILT_LEN-2:0], tk.raw_in};
         if (&s_next.hist) s_next.filt = 1'b1;
         else if (~|s_next.hist) s_next.filt = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) s_reg <= '0;
      else s_reg <= s_next;
   end

   assign tk.count_tick = tick_of(tk.count_clock_select, s_reg.div);
   assign tk.filter_tick = tick_of(tk.filter_clock_select, s_reg.div);
   assign tk.filt_in = s_reg.filt;

   tick_rate_a: assert property (@(posedge clk) disable iff (rst)
      (tk.count_clock_select == 4'h1 && tk.count_tick) |=> !tk.count_tick)
      else $error("Divide by two ticked twice in a row");
   reserved_idle_a: assert property (@(posedge clk) disable iff (rst)
      tk.count_clock_select[3] |-> !tk.count_tick)
      else $error("Reserved clock code produced a tick");
endmodule
`default_nettype wire

// [hdl/tcer_timer.sv]
// Sixteen-bit timer with clock, event and reload control over Avalon-MM
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Bits 11:8 pick filter sampling clock
// - Bits 3:0 pick counter advance clock
// - Event source: pin when set, else chain
// - Event edges: fall, rise, both, none
// - One-shot start: fall, rise, either, immediate
// - Measure intervals: fall, rise, both, none
// - Reload resets FFFFh, lower limit otherwise
// - Event mode reload is directional limit
// - New reload applied at wrap, or at once while disabled
// - Mode field: timer, event, oneshot, measure
// - Direction bit set counts up in event mode
module tcer_timer (
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire logic [3:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   input wire logic TIMER_INPUT_PIN,
   input wire logic PREV_OVERFLOW,
   output logic OVERFLOW
);
   typedef struct packed {
      logic [11:0] clk_evt;
      logic [15:0] reload;
      logic [15:0] limit;
      logic [15:0] count;
      logic [1:0] mode;
      logic dir;
      logic enable;
      logic running;
      logic pin_prev;
      logic ack;
      logic [31:0] rdata;
      logic ovf;
   } tcer_st_type;
   tcer_st_type s_reg, s_next;

   tcer_tick_if tk ();
   tcer_tickgen u_tickgen (
      .clk(CORE_CLK),
      .rst(RST),
      .tk(tk)
   );

   logic rise, fall, edge_hit, wr, rd;
   logic [1:0] edge_sel;
   logic [15:0] wdata16;

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
      merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
   endfunction

   always_comb begin
      edge_sel = s_reg.clk_evt[tcer_pkg::TCER_EDGE_MSB:tcer_pkg::TCER_EDGE_LSB];
      rise = tk.filt_in & ~s_reg.pin_prev;
      fall = ~tk.filt_in & s_reg.pin_prev;
      case (tcer_pkg::tcer_edge_type'(edge_sel))
         tcer_pkg::TCER_EDGE_FALL: edge_hit = fall;
         tcer_pkg::TCER_EDGE_RISE: edge_hit = rise;
         tcer_pkg::TCER_EDGE_BOTH: edge_hit = rise | fall;
         default: edge_hit = 1'b0;
      endcase
   end

   // Write lands at the edge where waitrequest is seen low, as the master expects
   assign wr = AVS_WRITE & s_reg.ack;
   assign rd = AVS_READ & ~s_reg.ack;
   assign wdata16 = merge16(s_reg.reload, AVS_WRITEDATA, AVS_BYTEENABLE);

   always_comb begin
      s_next = s_reg;
      s_next.ack = (AVS_READ | AVS_WRITE) & ~s_reg.ack;
      s_next.pin_prev = tk.filt_in;
      s_next.ovf = 1'b0;
      s_next.rdata = 32'h0000_0000;
      if (wr) begin
         case (AVS_ADDRESS)
            tcer_pkg::TCER_OFS_MODE_CTRL: begin
               if (AVS_BYTEENABLE[0]) begin
                  s_next.enable = AVS_WRITEDATA[tcer_pkg::TCER_EN_BIT];
                  s_next.mode = AVS_WRITEDATA[tcer_pkg::TCER_MODE_MSB:tcer_pkg::TCER_MODE_LSB];
                  s_next.dir = AVS_WRITEDATA[tcer_pkg::TCER_DIR_BIT];
                  s_next.running = 1'b0;
               end
            end
            tcer_pkg::TCER_OFS_CLK_EVT: begin
               if (AVS_BYTEENABLE[0]) begin
                  s_next.clk_evt[7:5] = AVS_WRITEDATA[7:5];
                  s_next.clk_evt[3:0] = AVS_WRITEDATA[3:0];
               end
               if (AVS_BYTEENABLE[1]) s_next.clk_evt[11:8] = AVS_WRITEDATA[11:8];
            end
            tcer_pkg::TCER_OFS_RELOAD: begin
               s_next.reload = wdata16;
               // Disabled timer takes the new limit at once, an enabled one waits
               if (!s_reg.enable) s_next.limit = wdata16;
            end
            default: ;
         endcase
      end
      if (rd) begin
         case (AVS_ADDRESS)
            tcer_pkg::TCER_OFS_MODE_CTRL:
               s_next.rdata = {27'h0, s_reg.dir, s_reg.mode, 1'b0, s_reg.enable};
            tcer_pkg::TCER_OFS_CLK_EVT: s_next.rdata = {20'h0, s_reg.clk_evt & 12'hFEF};
            tcer_pkg::TCER_OFS_RELOAD: s_next.rdata = {16'h0, s_reg.reload};
            tcer_pkg::TCER_OFS_COUNT: s_next.rdata = {16'h0, s_reg.count};
            default: s_next.rdata = 32'h0000_0000;
         endcase
      end
      if (s_reg.enable && !wr) begin
         case (tcer_pkg::tcer_mode_type'(s_reg.mode))
            tcer_pkg::TCER_MODE_TIMER: begin
               if (tk.count_tick) begin
                  if (s_reg.count <= s_reg.limit) begin
                     s_next.count = tcer_pkg::TCER_CNT_MAX;
                     s_next.limit = s_reg.reload;
                     s_next.ovf = 1'b1;
                  end else s_next.count = s_reg.count - tcer_pkg::TCER_CNT_ONE;
               end
            end
            tcer_pkg::TCER_MODE_EVENT: begin
               // Chain input bypasses the filter, it is already a clean pulse
               if (s_reg.clk_evt[tcer_pkg::TCER_EVSRC_BIT] ? edge_hit : PREV_OVERFLOW) begin
                  if (s_reg.dir) begin
                     if (s_reg.count >= s_reg.limit) begin
                        s_next.count = tcer_pkg::TCER_CNT_MIN;
                        s_next.limit = s_reg.reload;
                        s_next.ovf = 1'b1;
                     end else s_next.count = s_reg.count + tcer_pkg::TCER_CNT_ONE;
                  end else begin
                     if (s_reg.count <= s_reg.limit) begin
                        s_next.count = tcer_pkg::TCER_CNT_MAX;
                        s_next.limit = s_reg.reload;
                        s_next.ovf = 1'b1;
                     end else s_next.count = s_reg.count - tcer_pkg::TCER_CNT_ONE;
                  end
               end
            end
            tcer_pkg::TCER_MODE_ONESHOT: begin
               if (!s_reg.running) begin
                  if (edge_hit || edge_sel == tcer_pkg::TCER_EDGE_NONE) begin
                     s_next.running = 1'b1;
                     s_next.count = tcer_pkg::TCER_CNT_MAX;
                  end
               end else if (tk.count_tick) begin
                  if (s_reg.count <= s_reg.limit) begin
                     s_next.running = 1'b0;
                     s_next.enable = 1'b0;
                     s_next.limit = s_reg.reload;
                     s_next.ovf = 1'b1;
                  end else s_next.count = s_reg.count - tcer_pkg::TCER_CNT_ONE;
               end
            end
            default: begin
               // Measurement: the count shows ticks since the last chosen edge
               if (edge_hit || (edge_sel == tcer_pkg::TCER_EDGE_BOTH && fall)) begin
                  s_next.count = tcer_pkg::TCER_CNT_MIN;
               end else if (tk.count_tick && s_reg.count != tcer_pkg::TCER_CNT_MAX) begin
                  s_next.count = s_reg.count + tcer_pkg::TCER_CNT_ONE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         s_reg <= '0;
         s_reg.clk_evt <= tcer_pkg::TCER_CLK_EVT_RST;
         s_reg.reload <= tcer_pkg::TCER_RELOAD_RST;
         s_reg.limit <= tcer_pkg::TCER_RELOAD_RST;
         s_reg.count <= tcer_pkg::TCER_CNT_MAX;
      end else begin
         s_reg <= s_next;
      end
   end

   assign tk.count_clock_select = s_reg.clk_evt[tcer_pkg::TCER_COUNT_CLOCK_SELECT_MSB:tcer_pkg::TCER_COUNT_CLOCK_SELECT_LSB];
   assign tk.filter_clock_select = s_reg.clk_evt[tcer_pkg::TCER_FILTER_CLOCK_SELECT_MSB:tcer_pkg::TCER_FILTER_CLOCK_SELECT_LSB];
   assign tk.raw_in = TIMER_INPUT_PIN;
   assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~s_reg.ack;
   assign AVS_READDATA = s_reg.rdata;
   assign OVERFLOW = s_reg.ovf;

   reload_hold_a: assert property (@(posedge CORE_CLK) disable iff (RST)
      (s_reg.enable && !s_next.ovf && !wr) |=> $stable(s_reg.limit))
      else $error("Limit changed while running without a wrap");
   down_wrap_a: assert property (@(posedge CORE_CLK) disable iff (RST)
      (s_reg.enable && s_reg.mode == 2'b01 && !s_reg.dir && s_next.ovf && !wr)
      |=> s_reg.count == 16'hFFFF)
      else $error("Down count did not wrap to top");
   up_step_a: assert property (@(posedge CORE_CLK) disable iff (RST)
      (s_reg.enable && !wr && s_reg.mode == 2'b01 && s_reg.dir && !s_reg.clk_evt[7] && PREV_OVERFLOW
      && s_reg.count < s_reg.limit) |=> s_reg.count == $past(s_reg.count) + 16'h0001)
      else $error("Chained up count missed a step");
   no_event_a: assert property (@(posedge CORE_CLK) disable iff (RST)
      (s_reg.enable && !wr && s_reg.mode == 2'b01 && s_reg.clk_evt[7:5] == 3'b111) |=> $stable(s_reg.count))
      else $error("Count moved with no event selected");
   oneshot_go_a: assert property (@(posedge CORE_CLK) disable iff (RST)
      (s_reg.enable && !wr && s_reg.mode == 2'b10 && !s_reg.running && s_reg.clk_evt[6:5] == 2'b11)
      |=> s_reg.running)
      else $error("Immediate one-shot did not start");
   measure_clear_a: assert property (@(posedge CORE_CLK) disable iff (RST)
      (s_reg.enable && !wr && s_reg.mode == 2'b11 && edge_hit) |=> s_reg.count == 16'h0000)
      else $error("Measurement did not restart on edge");
   bus_answer_a: assert property (@(posedge CORE_CLK) disable iff (RST)
      (AVS_READ && AVS_WAITREQUEST) |=> !AVS_WAITREQUEST)
      else $error("Read not answered in one cycle");
   clk_field_a: assert property (@(posedge CORE_CLK) disable iff (RST)
      tk.count_clock_select == s_reg.clk_evt[3:0] && tk.filter_clock_select == s_reg.clk_evt[11:8])
      else $error("Clock select fields miswired");
   reload_reset_a: assert property (@(posedge CORE_CLK) $fell(RST) |-> s_reg.reload == 16'hFFFF)
      else $error("Reload not at reset value");
endmodule
`default_nettype wire

// [test/tcer_pin_source.sv]
// Event source model driving the external timer input pin
`timescale 1ns/1ps
`default_nettype none
module tcer_pin_source (
   input wire logic clk,
   output logic pin
);
   initial pin = 1'b0;
   // Each level held for hold cycles, so the three-sample filter can pass it
   task automatic send(input int k, input int hold);
      repeat (k) begin
         repeat (hold) @(posedge clk);
         pin <= 1'b1;
         repeat (hold) @(posedge clk);
         pin <= 1'b0;
      end
      repeat (hold) @(posedge clk);
   endtask
endmodule
`default_nettype wire

// [test/tcer_timer_test.sv]
// Self-checking bench for the timer clock, event and reload slice
`timescale 1ns/1ps
`default_nettype none
module tcer_timer_test;
   logic CORE_CLK = 1'b0;
   logic RST = 1'b1;
   logic [3:0] AVS_ADDRESS = 4'h0;
   logic AVS_READ = 1'b0;
   logic AVS_WRITE = 1'b0;
   logic [31:0] AVS_WRITEDATA = 32'h0;
   logic [31:0] AVS_READDATA;
   logic AVS_WAITREQUEST;
   logic TIMER_INPUT_PIN;
   logic PREV_OVERFLOW = 1'b0;
   logic OVERFLOW;
   int n_mismatch = 0;
   int n_checks = 0;
   int cyc = 0;
   int ovf_n = 0;
   int ovf_at = 0;
   always #2.5 CORE_CLK = ~CORE_CLK;
   tcer_timer dut (.CORE_CLK(CORE_CLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
      .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(4'hF),
      .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
      .TIMER_INPUT_PIN(TIMER_INPUT_PIN), .PREV_OVERFLOW(PREV_OVERFLOW), .OVERFLOW(OVERFLOW));
   tcer_pin_source src (.clk(CORE_CLK), .pin(TIMER_INPUT_PIN));
   always @(posedge CORE_CLK) begin
      cyc <= cyc + 1;
      if (OVERFLOW === 1'b1) begin
         ovf_n <= ovf_n + 1;
         ovf_at <= cyc;
      end
   end
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic give_up(input string what);
      n_mismatch++;
      $display("unexpected at %0t: timeout in %s", $time, what);
      final_report();
   endtask
   // Waitrequest and read data are taken at the rising edge, then the request drops
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
      int i;
      @(posedge CORE_CLK);
      AVS_ADDRESS <= a;
      AVS_WRITEDATA <= d;
      AVS_WRITE <= w;
      AVS_READ <= ~w;
      i = 0;
      do begin
         @(posedge CORE_CLK);
         i++;
      end while (AVS_WAITREQUEST !== 1'b0 && i < 20);
      if (i >= 20) give_up("bus");
      q = AVS_READDATA;
      AVS_WRITE <= 1'b0;
      AVS_READ <= 1'b0;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] q);
      bus(1'b0, a, 32'h0, q);
   endtask
   task automatic wait_ovf(output int at);
      int n;
      int i;
      n = ovf_n;
      for (i = 0; i < 3000 && ovf_n == n; i++) @(posedge CORE_CLK);
      if (ovf_n == n) give_up("overflow");
      at = ovf_at;
   endtask
   task automatic t_regs();
      logic [3:0] a[5] = '{4'h0, 4'h4, 4'h8, 4'hC, 4'h1};
      logic [31:0] v[5] = '{32'h0, 32'h0, 32'h0000_FFFF, 32'h0000_FFFF, 32'h0};
      logic [31:0] q;
      for (int i = 0; i < 5; i++) begin
         rd(a[i], q);
         chk(q, v[i], "reset value");
      end
      wr(4'h4, 32'hFFFF_FFFF);
      rd(4'h4, q);
      chk(q, 32'h0000_0FEF, "control fields");
      wr(4'h4, 32'h0);
      wr(4'h2, 32'hFFFF_FFFF);
      rd(4'h2, q);
      chk(q, 32'h0, "unmapped");
      wr(4'hC, 32'h0);
      rd(4'hC, q);
      chk(q, 32'h0000_FFFF, "count read only");
      wr(4'h8, 32'hFFFF_1234);
      rd(4'h8, q);
      chk(q, 32'h0000_1234, "reload field");
   endtask
   task automatic period(input logic [3:0] code, input logic [15:0] rl, output int p);
      int t0;
      int t1;
      wr(4'h0, 32'h0);
      wr(4'h8, {16'h0, rl});
      wr(4'h4, {28'h0, code});
      wr(4'h0, 32'h1);
      wait_ovf(t0);
      wait_ovf(t1);
      p = t1 - t0;
   endtask
   task automatic t_timer();
      int pa;
      int pb;
      int t0;
      int t1;
      int n;
      period(4'h0, 16'hFFFD, pa);
      period(4'h1, 16'hFFFD, pb);
      chk(pb, 2 * pa, "half rate period");
      period(4'h0, 16'hFFFB, pb);
      chk(pb, pa + 2, "lower limit period");
      period(4'h0, 16'hFF00, pa);
      t1 = ovf_at;
      wr(4'h8, 32'h0000_FFFE);
      wait_ovf(t0);
      chk(t0 - t1 >= pa, 1, "old limit kept");
      wait_ovf(t1);
      chk(t1 - t0 < 8, 1, "new limit at wrap");
      // Reserved code freezes the counter rather than guessing a rate
      wr(4'h4, 32'h8);
      repeat (4) @(posedge CORE_CLK);
      n = ovf_n;
      repeat (300) @(posedge CORE_CLK);
      chk(ovf_n, n, "reserved clock code");
   endtask
   task automatic t_event(input logic s, input logic [1:0] e, input logic up, input int k, input int exp);
      logic [31:0] c0;
      logic [31:0] c1;
      logic [15:0] d;
      wr(4'h0, 32'h0);
      // Down count needs a low floor, the top value would wrap on every event
      wr(4'h8, up ? 32'h0000_FFFF : 32'h0000_0001);
      wr(4'h4, {24'h0, s, e, 5'h0});
      wr(4'h0, {27'h0, up, 4'h5});
      rd(4'hC, c0);
      src.send(k, s ? 8 : 12);
      repeat (s ? 0 : k) begin
         @(posedge CORE_CLK);
         PREV_OVERFLOW <= 1'b1;
         @(posedge CORE_CLK);
         PREV_OVERFLOW <= 1'b0;
      end
      rd(4'hC, c1);
      d = up ? c1[15:0] - c0[15:0] : c0[15:0] - c1[15:0];
      chk({16'h0, d}, exp, "event count");
   endtask
   task automatic t_oneshot(input logic [1:0] e);
      int n;
      logic [31:0] q;
      wr(4'h0, 32'h0);
      wr(4'h8, 32'h0000_FFF8);
      wr(4'h4, {25'h0, e, 5'h0});
      n = ovf_n;
      wr(4'h0, 32'h9);
      repeat (40) @(posedge CORE_CLK);
      chk(ovf_n, n + (e == 2'b11), "start before edge");
      if (e != 2'b11) src.send(1, 10);
      repeat (40) @(posedge CORE_CLK);
      chk(ovf_n, n + 1, "one shot end");
      rd(4'h0, q);
      chk(q[0], 1'b0, "enable cleared");
   endtask
   task automatic t_measure(input logic [1:0] e, input int lo, input int hi);
      logic [31:0] q;
      wr(4'h0, 32'h0);
      wr(4'h4, {25'h0, e, 5'h0});
      wr(4'h0, 32'hD);
      src.send(1, 20);
      rd(4'hC, q);
      if (q[15:0] < lo || q[15:0] > hi) begin
         n_mismatch++;
         $display("unexpected at %0t: measured %0d", $time, q[15:0]);
      end
      n_checks++;
   endtask
   initial begin
      int ev_exp[4] = '{3, 3, 6, 0};
      repeat (12) @(posedge CORE_CLK);
      RST <= 1'b0;
      t_regs();
      $display("test registers done");
      t_timer();
      $display("test timer done");
      for (int e = 0; e < 4; e++) t_event(1'b1, e[1:0], 1'b1, 3, ev_exp[e]);
      t_event(1'b1, 2'b01, 1'b0, 4, 4);
      t_event(1'b0, 2'b01, 1'b1, 5, 5);
      $display("test event done");
      for (int e = 0; e < 4; e++) t_oneshot(e[1:0]);
      $display("test one shot done");
      t_measure(2'b01, 32, 42);
      t_measure(2'b10, 12, 22);
      $display("test measurement done");
      final_report();
   end
endmodule
`default_nettype wire
